// ===== arb_pkg.sv
// Constants and state encodings shared by both arbiter ends
// How it works
// - Access controller steps on falling link clock
// - Access controller resets into requesting state
// - Enter requesting only while backplane request idle
// - Requesting drives chain out low, asserts request
// - Grant when chain in active, acknowledge idle
// - Granted passes chain, asserts grant and acknowledge
// - Release returns idle; idle passes chain through
// - Request controller steps on falling link clock
// - Local asserts nothing; offboard need starts request
// - Request held until grant, then bus owned
// - Owned enables acknowledge drive, flags availability
// - Owned until unlocked foreign request arrives
// - Releasing asserts release, keeps acknowledge, awaits ungrant
// - Request controller resets into requesting state
// - Host card treats chain input always active
// - Arbitration takes three link clocks per winner
// - Same-period requesters served before later ones
// - Owner keeps bus until someone else requests
// - CPU lock prefix holds off bus release
// - Exclusive hold bit requests and keeps bus
// - CPU waits until bus available
// - Foreign request raised on CPU clock, only owned
// - Request gate enables backplane request drive
package arb_pkg;

    // ------------------------------------------------------------
    // Access controller states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BAC_IDLE  = 2'h0,
        BAC_BUSRQ = 2'h1,
        BAC_GRANT = 2'h2
    } bac_state_e;

    // ------------------------------------------------------------
    // Request controller states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RQC_LOCAL     = 2'h0,
        RQC_REQUEST   = 2'h1,
        RQC_OWNED     = 2'h2,
        RQC_RELEASING = 2'h3
    } rqc_state_e;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam bac_state_e BAC_RESET_STATE = BAC_BUSRQ;
    localparam rqc_state_e RQC_RESET_STATE = RQC_REQUEST;
    localparam int         ARB_CYCLE_CLOCKS = 3;
    localparam int         M_SYNC_W = 2;
    localparam int         M_BIT_BUSRQ = 0;
    localparam int         M_BIT_AVAIL = 1;
    localparam int         L_SYNC_W = 4;
    localparam int         L_BIT_CE = 0;
    localparam int         L_BIT_OFFB = 1;
    localparam int         L_BIT_UNLK = 2;
    localparam int         L_BIT_HOLD = 3;

    // Majority of last two sync stages: change counts once they agree
    function automatic logic [L_SYNC_W-1:0] agree(
        input logic [L_SYNC_W-1:0] s2,
        input logic [L_SYNC_W-1:0] s3,
        input logic [L_SYNC_W-1:0] q
    );
        agree = (s2 & s3) | (q & (s2 ^ s3));
    endfunction

endpackage

// ===== arb_link_if.sv
// Backplane arbitration wires between the card and a peer arbiter
`timescale 1ns/1ps
interface arb_link_if (
    input wire logic cntrl_n
);
    logic dev_busrq_out;
    logic dev_busrq_oe;
    logic dev_busak_out;
    logic dev_busak_oe;
    logic peer_busrq_out;
    logic peer_busrq_oe;
    logic peer_busak_out;
    logic peer_busak_oe;
    logic busrq_n;
    logic busak_n;
    logic peer_pci;
    logic peer_pco;
    logic dev_pco;
    logic dev_pci;

    // Open-drain lines: low while any party drives
    assign busrq_n = ~((dev_busrq_oe & ~dev_busrq_out)
                    | (peer_busrq_oe & ~peer_busrq_out));
    assign busak_n = ~((dev_busak_oe & ~dev_busak_out)
                    | (peer_busak_oe & ~peer_busak_out));
    // Peer sits to the right, its chain out feeds the card
    assign dev_pci = peer_pco;

    modport dev (
        input  cntrl_n,
        input  busrq_n,
        input  busak_n,
        input  dev_pci,
        output dev_busrq_out,
        output dev_busrq_oe,
        output dev_busak_out,
        output dev_busak_oe,
        output dev_pco
    );

    modport peer (
        input  cntrl_n,
        input  busrq_n,
        input  busak_n,
        input  peer_pci,
        output peer_busrq_out,
        output peer_busrq_oe,
        output peer_busak_out,
        output peer_busak_oe,
        output peer_pco
    );
endinterface

// ===== bus_access_controller.sv
// Backplane access state machine with request drive gate
`timescale 1ns/1ps
module bus_access_controller
    import arb_pkg::*;
(
    input  wire logic cntrl_n,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic request,
    input  wire logic release_req,
    input  wire logic drive_en,
    input  wire logic pci,
    input  wire logic busrq_line,
    input  wire logic busak_line,
    output logic      pco,
    output logic      grant,
    output logic      busrq_oe,
    output logic      busak_oe
);

    bac_state_e state_q;
    bac_state_e state_d;
    logic       gate_q;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            BAC_IDLE: begin
                if (request && !busrq_line) begin
                    state_d = BAC_BUSRQ;
                end
            end
            BAC_BUSRQ: begin
                if (pci && !busak_line) begin
                    state_d = BAC_GRANT;
                end
            end
            BAC_GRANT: begin
                if (release_req) begin
                    state_d = BAC_IDLE;
                end
            end
            default: state_d = BAC_IDLE;
        endcase
    end

    // State register on the falling link clock
    always_ff @(negedge cntrl_n or negedge resetn) begin
        if (!resetn) begin
            state_q <= BAC_RESET_STATE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // Request gate: opens only on an idle line with chain in high
    always_ff @(negedge cntrl_n or negedge resetn) begin
        if (!resetn) begin
            gate_q <= 1'b0;
        end else if (ce) begin
            if (!gate_q) begin
                gate_q <= (state_q == BAC_BUSRQ) && !busrq_line
                          && pci;
            end else if (!pci || (state_q == BAC_IDLE)
                         || ((state_q == BAC_GRANT) && !busrq_line)) begin
                gate_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pco      = (state_q == BAC_BUSRQ) ? 1'b0 : pci;
    assign grant    = (state_q == BAC_GRANT);
    assign busrq_oe = (state_q == BAC_BUSRQ) && gate_q;
    assign busak_oe = (state_q == BAC_GRANT) && drive_en;

endmodule

// ===== peer_arbiter.sv
// Far-end arbiter of another card, driven straight by user levels
`timescale 1ns/1ps
module peer_arbiter
    import arb_pkg::*;
(
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic is_host,
    input  wire logic want_bus,
    input  wire logic release_bus,
    output logic      owns_bus,
    arb_link_if.peer  link
);

    logic pci_eff;

    // Host ignores its chain input
    assign pci_eff = is_host | link.peer_pci;

    // Open-drain lines only ever pull low
    assign link.peer_busrq_out = 1'b0;
    assign link.peer_busak_out = 1'b0;

    // Peer side uses the same access machine on the link clock
    bus_access_controller u_bac (
        .cntrl_n     (link.cntrl_n),
        .resetn      (resetn),
        .ce          (ce),
        .request     (want_bus),
        .release_req (release_bus),
        .drive_en    (1'b1),
        .pci         (pci_eff),
        .busrq_line  (~link.busrq_n),
        .busak_line  (~link.busak_n),
        .pco         (link.peer_pco),
        .grant       (owns_bus),
        .busrq_oe    (link.peer_busrq_oe),
        .busak_oe    (link.peer_busak_oe)
    );

endmodule

// ===== arbiter_card.sv
// Card-side arbiter: CPU request controller, CPU sync and lock logic
`timescale 1ns/1ps
module arbiter_card
    import arb_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic is_host,
    input  wire logic offboard_access_needed,
    input  wire logic addr_stable,
    input  wire logic cycle_done,
    input  wire logic cpu_lock,
    input  wire logic exclusive_hold_bit,
    output logic      cpu_ready,
    output logic      bus_available_to_cpu,
    output logic      bus_status,
    arb_link_if.dev   link
);

    // ------------------------------------------------------------
    // CPU clock domain declarations
    // ------------------------------------------------------------
    logic [M_SYNC_W-1:0] m_s1_q;
    logic [M_SYNC_W-1:0] m_s2_q;
    logic [M_SYNC_W-1:0] m_s3_q;
    logic [M_SYNC_W-1:0] m_q;
    logic [M_SYNC_W-1:0] m_in;
    logic                synced_offboard_access_q;
    logic                unlocked_foreign_request_q;
    logic                lock;
    logic                foreign_rq;

    // ------------------------------------------------------------
    // Link clock domain declarations
    // ------------------------------------------------------------
    logic [L_SYNC_W-1:0] l_s1_q;
    logic [L_SYNC_W-1:0] l_s2_q;
    logic [L_SYNC_W-1:0] l_s3_q;
    logic [L_SYNC_W-1:0] l_q;
    logic [L_SYNC_W-1:0] l_in;
    logic                ce_l;
    rqc_state_e          rqc_q;
    rqc_state_e          rqc_d;
    logic                owned_q;
    logic                request;
    logic                release_req;
    logic                ack_drive_enable;
    logic                grant;
    logic                pci_eff;
    logic [L_SYNC_W-1:0] l_agree;
    logic [L_SYNC_W-1:0] m_agree;

    // ------------------------------------------------------------
    // Link to CPU crossing
    // ------------------------------------------------------------

    // Foreign request level and bus ownership enter the CPU domain
    assign m_in[M_BIT_BUSRQ] = ~link.busrq_n;
    assign m_in[M_BIT_AVAIL] = owned_q;

    // Filtered result reused for both widths through the shared helper
    assign m_agree = agree({{(L_SYNC_W-M_SYNC_W){1'b0}}, m_s2_q},
                           {{(L_SYNC_W-M_SYNC_W){1'b0}}, m_s3_q},
                           {{(L_SYNC_W-M_SYNC_W){1'b0}}, m_q});

    // Three-stage synchroniser, change taken once stages two, three agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            m_s1_q <= '0;
            m_s2_q <= '0;
            m_s3_q <= '0;
            m_q    <= '0;
        end else if (ce) begin
            m_s1_q <= m_in;
            m_s2_q <= m_s1_q;
            m_s3_q <= m_s2_q;
            m_q    <= m_agree[M_SYNC_W-1:0];
        end
    end

    // Ownership as seen by the CPU, also the polled status
    assign bus_available_to_cpu = m_q[M_BIT_AVAIL];
    assign bus_status           = m_q[M_BIT_AVAIL];
    assign foreign_rq           = m_q[M_BIT_BUSRQ];

    // ------------------------------------------------------------
    // CPU side request, lock and wait logic
    // ------------------------------------------------------------

    // Offboard need latched on stable address, cleared when cycle ends
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            synced_offboard_access_q <= 1'b0;
        end else if (ce) begin
            if (addr_stable && offboard_access_needed) begin
                synced_offboard_access_q <= 1'b1;
            end else if (cycle_done && cpu_ready) begin
                synced_offboard_access_q <= 1'b0;
            end
        end
    end

    // Any lock source keeps the bus: open cycle, prefix, hold bit
    assign lock = synced_offboard_access_q | cpu_lock
                | exclusive_hold_bit;

    // Foreign request passed on only while owned and unlocked
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            unlocked_foreign_request_q <= 1'b0;
        end else if (ce) begin
            unlocked_foreign_request_q <= foreign_rq && !lock
                                          && bus_available_to_cpu;
        end
    end

    // CPU waits while an offboard cycle is pending without the bus
    assign cpu_ready = !synced_offboard_access_q
                       || bus_available_to_cpu;

    // ------------------------------------------------------------
    // CPU to link crossing
    // ------------------------------------------------------------
    assign l_in[L_BIT_CE]   = ce;
    assign l_in[L_BIT_OFFB] = synced_offboard_access_q;
    assign l_in[L_BIT_UNLK] = unlocked_foreign_request_q;
    assign l_in[L_BIT_HOLD] = exclusive_hold_bit;
    assign l_agree          = agree(l_s2_q, l_s3_q, l_q);

    // Synchroniser runs free so the clock enable itself can cross
    always_ff @(negedge link.cntrl_n or negedge resetn) begin
        if (!resetn) begin
            l_s1_q <= '0;
            l_s2_q <= '0;
            l_s3_q <= '0;
            l_q    <= '0;
        end else begin
            l_s1_q <= l_in;
            l_s2_q <= l_s1_q;
            l_s3_q <= l_s2_q;
            l_q    <= l_agree;
        end
    end

    assign ce_l = l_q[L_BIT_CE];

    // ------------------------------------------------------------
    // CPU request controller
    // ------------------------------------------------------------

    // Next state of the request controller
    always_comb begin
        rqc_d = rqc_q;
        case (rqc_q)
            RQC_LOCAL: begin
                if (l_q[L_BIT_OFFB] || l_q[L_BIT_HOLD]) begin
                    rqc_d = RQC_REQUEST;
                end
            end
            RQC_REQUEST: begin
                if (grant) begin
                    rqc_d = RQC_OWNED;
                end
            end
            RQC_OWNED: begin
                if (l_q[L_BIT_UNLK]) begin
                    rqc_d = RQC_RELEASING;
                end
            end
            RQC_RELEASING: begin
                if (!grant) begin
                    rqc_d = RQC_LOCAL;
                end
            end
            default: rqc_d = RQC_LOCAL;
        endcase
    end

    // State and ownership flag on the falling link clock
    always_ff @(negedge link.cntrl_n or negedge resetn) begin
        if (!resetn) begin
            rqc_q   <= RQC_RESET_STATE;
            owned_q <= 1'b0;
        end else if (ce_l) begin
            rqc_q   <= rqc_d;
            owned_q <= (rqc_d == RQC_OWNED);
        end
    end

    // Decoded controller outputs; local state asserts none
    assign request          = (rqc_q == RQC_REQUEST);
    assign release_req      = (rqc_q == RQC_RELEASING);
    assign ack_drive_enable = (rqc_q == RQC_OWNED)
                            || (rqc_q == RQC_RELEASING);

    // ------------------------------------------------------------
    // Bus access controller and backplane pins
    // ------------------------------------------------------------

    // Host card treats its chain input as always active
    assign pci_eff = is_host | link.dev_pci;

    // Open-drain lines only ever pull low
    assign link.dev_busrq_out = 1'b0;
    assign link.dev_busak_out = 1'b0;

    bus_access_controller u_bac (
        .cntrl_n     (link.cntrl_n),
        .resetn      (resetn),
        .ce          (ce_l),
        .request     (request),
        .release_req (release_req),
        .drive_en    (ack_drive_enable),
        .pci         (pci_eff),
        .busrq_line  (~link.busrq_n),
        .busak_line  (~link.busak_n),
        .pco         (link.dev_pco),
        .grant       (grant),
        .busrq_oe    (link.dev_busrq_oe),
        .busak_oe    (link.dev_busak_oe)
    );

endmodule

// ===== arb_link_chk.sv
// Assertions on the backplane arbitration wires
`timescale 1ns/1ps
module arb_link_chk (
    input wire logic cntrl_n,
    input wire logic resetn,
    input wire logic busrq_n,
    input wire logic busak_n,
    input wire logic dev_busrq_oe,
    input wire logic dev_busak_oe,
    input wire logic peer_busrq_oe,
    input wire logic peer_busak_oe,
    input wire logic dev_pci,
    input wire logic dev_pco,
    input wire logic peer_pco
);
    // All link logic steps on the falling control clock
    default clocking cb @(negedge cntrl_n);
    endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    // Card owns while nobody requests, eight edges running
    sequence held_quiet;
        (dev_busak_oe && busrq_n) [*8];
    endsequence

    // A party starts pulling the request line
    sequence gate_open(oe);
        $rose(oe);
    endsequence

    // Peer left the bus while the card still asks with chain in high
    sequence peer_leaves;
        $fell(peer_busak_oe) && !busrq_n && dev_pci;
    endsequence

    // Card granted on the next edge, acknowledge driven one edge later
    sequence card_takes;
        ##2 dev_busak_oe;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    one_owner_a: assert property (
        !(dev_busak_oe && peer_busak_oe))
        else $error("Both ends acknowledge at once");
    dev_req_chain_a: assert property (
        dev_busrq_oe |-> !dev_pco)
        else $error("Card chain out high while requesting");
    peer_req_chain_a: assert property (
        peer_busrq_oe |-> !peer_pco)
        else $error("Peer chain out high while requesting");
    grant_chain_a: assert property (
        dev_busak_oe |-> dev_pco == dev_pci)
        else $error("Card chain not passed while granted");
    dev_gate_a: assert property (
        gate_open(dev_busrq_oe) |-> $past(busrq_n) && $past(dev_pci))
        else $error("Card request raised while line busy");
    peer_gate_a: assert property (
        gate_open(peer_busrq_oe) |-> $past(busrq_n))
        else $error("Peer request raised while line busy");
    chain_loss_a: assert property (
        dev_busrq_oe && !dev_pci |=> !dev_busrq_oe)
        else $error("Card request kept after chain loss");
    peer_grant_a: assert property (
        $rose(peer_busak_oe) |-> $past(busak_n))
        else $error("Peer granted over a live acknowledge");
    changeover_a: assert property (
        peer_leaves |-> card_takes)
        else $error("Changeover not done in three edges");
    hold_owner_a: assert property (
        held_quiet |=> dev_busak_oe)
        else $error("Card gave up bus with no requester");
endmodule

// ===== multiprocessor_bus_arbiter_tb.sv
// Self-checking bench: card arbiter facing a peer arbiter
`timescale 1ns/1ps
`define CHECK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("Error at %0t ns: got %b expected %b", \
                     $time, got, exp); \
        end \
    end
module multiprocessor_bus_arbiter_tb;
    logic mclk        = 1'b0;
    logic cntrl_n     = 1'b1;
    logic resetn      = 1'b0;
    logic offb        = 1'b0;
    logic addr_stable = 1'b0;
    logic cycle_done  = 1'b0;
    logic cpu_lock    = 1'b0;
    logic hold_bit    = 1'b0;
    logic peer_host   = 1'b0;
    logic want_bus    = 1'b0;
    logic release_bus = 1'b0;
    logic cpu_ready;
    logic bus_avail;
    logic bus_status;
    logic owns_bus;
    int   errors      = 0;
    int   checks_done = 0;

    // CPU clock, and a backplane clock offset in phase
    always #2 mclk = ~mclk;
    initial begin
        #0.9;
        forever #15 cntrl_n = ~cntrl_n;
    end

    // ------------------------------------------------------------
    // Design, link and checker
    // ------------------------------------------------------------
    arb_link_if link (.cntrl_n(cntrl_n));

    arbiter_card arbiter_card_inst (
        .mclk                  (mclk),
        .resetn                (resetn),
        .ce                    (1'b1),
        .is_host               (1'b0),
        .offboard_access_needed(offb),
        .addr_stable           (addr_stable),
        .cycle_done            (cycle_done),
        .cpu_lock              (cpu_lock),
        .exclusive_hold_bit    (hold_bit),
        .cpu_ready             (cpu_ready),
        .bus_available_to_cpu  (bus_avail),
        .bus_status            (bus_status),
        .link                  (link)
    );

    peer_arbiter peer_arbiter_inst (
        .resetn     (resetn),
        .ce         (1'b1),
        .is_host    (peer_host),
        .want_bus   (want_bus),
        .release_bus(release_bus),
        .owns_bus   (owns_bus),
        .link       (link)
    );

    arb_link_chk arb_link_chk_inst (
        .cntrl_n      (cntrl_n),
        .resetn       (resetn),
        .busrq_n      (link.busrq_n),
        .busak_n      (link.busak_n),
        .dev_busrq_oe (link.dev_busrq_oe),
        .dev_busak_oe (link.dev_busak_oe),
        .peer_busrq_oe(link.peer_busrq_oe),
        .peer_busak_oe(link.peer_busak_oe),
        .dev_pci      (link.dev_pci),
        .dev_pco      (link.dev_pco),
        .peer_pco     (link.peer_pco)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Card must keep the bus when any lock is up or nobody asks
    function automatic logic keeps(input logic lk, input logic hb,
                                   input logic pend, input logic frn);
        return !frn || lk || hb || pend;
    endfunction

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic falls(input int n);
        repeat (n) @(negedge cntrl_n);
        @(negedge mclk);
    endtask

    // Bounded wait for card (1) or peer (0) ownership to reach want
    task automatic wait_own(input logic card, input logic want);
        int i;
        i = 0;
        while (((card ? bus_avail : owns_bus) !== want) && i < 2000) begin
            @(negedge mclk);
            i++;
        end
        if (i >= 2000) begin
            errors++;
            $display("Error at %0t ns: handover stalled", $time);
        end
    endtask

    task automatic do_reset(input logic host, input logic pci);
        resetn = 1'b0;
        peer_host = host;
        link.peer_pci = pci;
        repeat (2) @(negedge cntrl_n);
        @(negedge mclk);
        `CHECK(bus_avail, 1'b0)
        `CHECK(cpu_ready, 1'b1)
        `CHECK(link.dev_busrq_oe, 1'b0)
        resetn = 1'b1;
    endtask

    task automatic cpu_cycle(input logic off);
        offb = off;
        addr_stable = 1'b1;
        @(negedge mclk);
        addr_stable = 1'b0;
        @(negedge mclk);
        `CHECK(cpu_ready, !off)
    endtask

    task automatic end_cycle();
        cycle_done = 1'b1;
        @(negedge mclk);
        cycle_done = 1'b0;
    endtask

    // Card wins the bus from the peer, then holds it under one lock
    task automatic lock_round(input int kind);
        logic kept;
        repeat ($urandom_range(1, 8)) @(negedge mclk);
        cpu_cycle(1'b0);
        cpu_cycle(1'b1);
        falls(6);
        `CHECK(bus_avail, 1'b0)
        // Chain loss closes the request gate, chain back reopens it
        link.peer_pci = 1'b0;
        falls(2);
        `CHECK(link.dev_busrq_oe, 1'b0)
        link.peer_pci = 1'b1;
        falls(2);
        `CHECK(link.dev_busrq_oe, 1'b1)
        release_bus = 1'b1;
        wait_own(1'b1, 1'b1);
        release_bus = 1'b0;
        `CHECK(cpu_ready, 1'b1)
        `CHECK(bus_status, 1'b1)
        `CHECK(owns_bus, 1'b0)
        if (kind != 2) end_cycle();
        falls(12);
        `CHECK(bus_avail, 1'b1)
        cpu_lock = (kind == 0);
        hold_bit = (kind == 1);
        want_bus = 1'b1;
        falls(20);
        kept = keeps(cpu_lock, hold_bit, kind == 2, 1'b1);
        `CHECK(bus_avail, kept)
        `CHECK(owns_bus, !kept)
        cpu_lock = 1'b0;
        hold_bit = 1'b0;
        if (kind == 2) end_cycle();
        wait_own(1'b0, 1'b1);
        want_bus = 1'b0;
        falls(4);
        `CHECK(bus_avail, 1'b0)
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        int start;
        void'($urandom(32'h223EF250));
        do_reset(1'b0, 1'b0);
        falls(10);
        `CHECK(owns_bus, 1'b0)
        `CHECK(link.peer_busrq_oe, 1'b0)
        link.peer_pci = 1'b1;
        wait_own(1'b0, 1'b1);
        `CHECK(owns_bus, 1'b1)
        start = $urandom_range(0, 2);
        for (int n = 0; n < 3; n++) begin
            lock_round((start + n) % 3);
        end
        do_reset(1'b1, 1'b0);
        wait_own(1'b0, 1'b1);
        `CHECK(owns_bus, 1'b1)
        end_of_test();
    end

    // Cuts a hang short
    initial begin
        #100000;
        errors++;
        $display("Error at %0t ns: watchdog expired", $time);
        end_of_test();
    end
endmodule
